// ### rtl/afc_top.sv
// ADC front-end control: two special function registers and analog controls.
// Assumes a synchronous SFR bus with one-cycle read and write strobes.
`timescale 1ns/1ps
module afc_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] analogDivider,
    input wire logic microsecondTick,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    output logic referenceClockSelect,
    output logic burnoutCurrentEnable,
    output logic internalReferenceEnable,
    output logic referenceLevelHigh,
    output logic inputBufferEnable,
    output logic [2:0] gainCode,
    output logic [7:0] gainValue,
    output logic [4:0] sampleMultiplier,
    output logic offsetDacEnable,
    output logic offsetDacNegative,
    output logic [6:0] offsetDacMagnitude,
    output logic modTick,
    output logic refTick
);
    logic [7:0] frontend_q;
    logic [7:0] offset_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic [7:0] gain_q;
    logic [4:0] mult_q;
    logic [4:0] mult_d;
    logic offsetEn_q;
    logic offsetNeg_q;
    logic [6:0] offsetMag_q;
    logic mod_q;
    logic ref_q;
    logic wrFront;
    logic wrOffset;

    afc_clk_if ck ();

    afc_clk_div u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .ck(ck)
    );

    assign ck.divider = analogDivider;
    assign ck.refSelTick = frontend_q[afc_pkg::REFSEL_BIT];
    assign ck.usecTick = microsecondTick;

    // Address decode
    always_comb begin
        wrFront = 1'b0;
        wrOffset = 1'b0;
        if (sfrWr && sfrAddr == afc_pkg::FRONTEND_ADDR) begin
            wrFront = 1'b1;
        end else if (sfrWr && sfrAddr == afc_pkg::OFFSET_ADDR) begin
            wrOffset = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frontend_q <= afc_pkg::FRONTEND_RESET;
        end else if (wrFront) begin
            frontend_q <= sfrWdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            offset_q <= afc_pkg::OFFSET_RESET;
        end else if (wrOffset) begin
            offset_q <= sfrWdata;
        end
    end

    // Readback; unmapped addresses read zero without a hit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (sfrRd && sfrAddr == afc_pkg::FRONTEND_ADDR) begin
            rdata_q <= frontend_q;
            hit_q <= 1'b1;
        end else if (sfrRd && sfrAddr == afc_pkg::OFFSET_ADDR) begin
            rdata_q <= offset_q;
            hit_q <= 1'b1;
        end else begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end
    end

    always_comb begin
        case (frontend_q[afc_pkg::GAIN_MSB:0])
            3'h3: mult_d = 5'h02;
            3'h4: mult_d = 5'h04;
            3'h5: mult_d = 5'h08;
            3'h6, 3'h7: mult_d = 5'h10;
            default: mult_d = 5'h01;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gain_q <= 8'h01;
            mult_q <= 5'h01;
        end else begin
            gain_q <= 8'h01 << frontend_q[afc_pkg::GAIN_MSB:0];
            mult_q <= mult_d;
        end
    end

    // sign and magnitude to analog; full 7Fh is the half-range limit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            offsetEn_q <= 1'b0;
            offsetNeg_q <= 1'b0;
            offsetMag_q <= 7'h00;
        end else begin
            offsetEn_q <= offset_q[afc_pkg::MAG_MSB:0] != 7'h00;
            offsetNeg_q <= offset_q[afc_pkg::SIGN_BIT] && (offset_q[afc_pkg::MAG_MSB:0] != 7'h00);
            offsetMag_q <= offset_q[afc_pkg::MAG_MSB:0] & afc_pkg::MAG_FULL;
        end
    end

    // Retime ticks so every output leaves a flip-flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mod_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            mod_q <= ck.modTick;
            ref_q <= ck.refTick;
        end
    end

    assign sfrRdata = rdata_q;
    assign sfrHit = hit_q;
    assign referenceClockSelect = frontend_q[afc_pkg::REFSEL_BIT];
    assign burnoutCurrentEnable = frontend_q[afc_pkg::BURNOUT_BIT];
    assign internalReferenceEnable = frontend_q[afc_pkg::REFEN_BIT];
    assign referenceLevelHigh = frontend_q[afc_pkg::REFHI_BIT];
    assign inputBufferEnable = frontend_q[afc_pkg::BUFEN_BIT];
    assign gainCode = frontend_q[afc_pkg::GAIN_MSB:0];
    assign gainValue = gain_q;
    assign sampleMultiplier = mult_q;
    assign offsetDacEnable = offsetEn_q;
    assign offsetDacNegative = offsetNeg_q;
    assign offsetDacMagnitude = offsetMag_q;
    assign modTick = mod_q;
    assign refTick = ref_q;
endmodule

// ### rtl/afc_pkg.sv
// Constants for the ADC front-end control block.
// Assumes an 8-bit special function register bus from the embedded controller.
package afc_pkg;
    localparam logic [7:0] FRONTEND_ADDR = 8'hDC;
    localparam logic [7:0] OFFSET_ADDR = 8'hE6;
    localparam logic [7:0] FRONTEND_RESET = 8'h30;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam int REFSEL_BIT = 7;
    localparam int BURNOUT_BIT = 6;
    localparam int REFEN_BIT = 5;
    localparam int REFHI_BIT = 4;
    localparam int BUFEN_BIT = 3;
    localparam int GAIN_MSB = 2;
    localparam int SIGN_BIT = 7;
    localparam int MAG_MSB = 6;
    localparam logic [6:0] MAG_FULL = 7'h7F;
    localparam int REF_DIV = 4;
    localparam int MOD_DIV = 64;
    localparam int REF_MAX_KHZ = 250;
    localparam int CLK_MHZ = 20;
endpackage

// ### rtl/afc_clk_if.sv
// Clock-divider settings and ticks shared between the top and the divider.
// Assumes a single system clock domain.
`timescale 1ns/1ps
interface afc_clk_if;
    logic [7:0] divider;
    logic refSelTick;
    logic usecTick;
    logic aclkTick;
    logic modTick;
    logic refTick;
    modport ctrl (output divider, output refSelTick, output usecTick, input aclkTick, input modTick, input refTick);
    modport div (input divider, input refSelTick, input usecTick, output aclkTick, output modTick, output refTick);
endinterface

// ### rtl/afc_clk_div.sv
// Analog, modulator and reference clock tick generator.
// Assumes divider and tick inputs are synchronous to clk_sys.
`timescale 1ns/1ps
module afc_clk_div (
    input wire logic clk_sys,
    input wire logic rst,
    afc_clk_if.div ck
);
    logic [7:0] aclkCnt_q;
    logic [5:0] modCnt_q;
    logic [1:0] refCnt_q;
    logic aclk_q;
    logic mod_q;
    logic ref_q;
    logic refSrc;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aclkCnt_q <= 8'h00;
            aclk_q <= 1'b0;
        end else if (aclkCnt_q >= ck.divider) begin
            aclkCnt_q <= 8'h00;
            aclk_q <= 1'b1;
        end else begin
            aclkCnt_q <= aclkCnt_q + 8'h01;
            aclk_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modCnt_q <= 6'h00;
            mod_q <= 1'b0;
        end else begin
            mod_q <= aclk_q && (modCnt_q == 6'(afc_pkg::MOD_DIV - 1));
            if (aclk_q) begin
                modCnt_q <= modCnt_q + 6'h01;
            end
        end
    end

    assign refSrc = ck.refSelTick ? ck.usecTick : aclk_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            refCnt_q <= 2'h0;
            ref_q <= 1'b0;
        end else begin
            ref_q <= refSrc && (refCnt_q == 2'(afc_pkg::REF_DIV - 1));
            if (refSrc) begin
                refCnt_q <= refCnt_q + 2'h1;
            end
        end
    end

    assign ck.aclkTick = aclk_q;
    assign ck.modTick = mod_q;
    assign ck.refTick = ref_q;
endmodule

// ### testbench/afc_top_asserts.sv
// Port checker for the front-end control block.
// Assumes it is bound into afc_top.
`timescale 1ns/1ps
module afc_top_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] sfrRdata,
    input wire logic sfrHit,
    input wire logic referenceClockSelect,
    input wire logic burnoutCurrentEnable,
    input wire logic internalReferenceEnable,
    input wire logic referenceLevelHigh,
    input wire logic inputBufferEnable,
    input wire logic [2:0] gainCode,
    input wire logic [7:0] gainValue,
    input wire logic [4:0] sampleMultiplier,
    input wire logic offsetDacEnable,
    input wire logic offsetDacNegative,
    input wire logic [6:0] offsetDacMagnitude
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [4:0] mulTab [8] = '{5'h01, 5'h01, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
    sequence s_ctrl_wr; sfrWr && sfrAddr == 8'hDC; endsequence
    sequence s_offset_wr; sfrWr && sfrAddr == 8'hE6; endsequence
    property p_fields; s_ctrl_wr |=> {referenceClockSelect, burnoutCurrentEnable, internalReferenceEnable,
        referenceLevelHigh, inputBufferEnable, gainCode} == $past(sfrWdata); endproperty
    a_fields: assert property (p_fields) else $error("control fields wrong");
    property p_gain; s_ctrl_wr ##1 1 |=> gainValue == 8'h01 << $past(sfrWdata[2:0], 2); endproperty
    a_gain: assert property (p_gain) else $error("gain value wrong");
    property p_mult; 1 |-> sampleMultiplier == mulTab[$past(gainCode)]; endproperty
    a_mult: assert property (p_mult) else $error("sample multiplier wrong");
    property p_offset; s_offset_wr ##1 1 |=> offsetDacMagnitude == $past(sfrWdata[6:0], 2)
        && offsetDacNegative == ($past(sfrWdata[7], 2) && offsetDacEnable); endproperty
    a_offset: assert property (p_offset) else $error("offset setting wrong");
    property p_offset_off; 1 |-> offsetDacEnable == (offsetDacMagnitude != 7'h00)
        && (offsetDacEnable || !offsetDacNegative); endproperty
    a_offset_off: assert property (p_offset_off) else $error("offset enable wrong");
    property p_rd_ctrl; sfrRd && sfrAddr == 8'hDC |=> sfrHit && sfrRdata == $past({referenceClockSelect,
        burnoutCurrentEnable, internalReferenceEnable, referenceLevelHigh, inputBufferEnable, gainCode}); endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
    property p_unmapped; sfrRd && sfrAddr != 8'hDC && sfrAddr != 8'hE6 |=> !sfrHit && sfrRdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_hold; !(sfrWr && sfrAddr == 8'hDC) |=> $stable(gainCode) && $stable(inputBufferEnable); endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");
endmodule
bind afc_top afc_top_asserts afc_top_asserts_i (.clk_sys, .rst, .sfrAddr, .sfrWdata, .sfrWr, .sfrRd, .sfrRdata,
    .sfrHit, .referenceClockSelect, .burnoutCurrentEnable, .internalReferenceEnable, .referenceLevelHigh,
    .inputBufferEnable, .gainCode, .gainValue, .sampleMultiplier, .offsetDacEnable, .offsetDacNegative,
    .offsetDacMagnitude);

// ### testbench/adc_frontend_control_test.sv
// Self-checking bench for the front-end control block.
// Assumes afc_top with its checker bound in; inputs change at falling edges.
`timescale 1ns/1ps
module adc_frontend_control_test;
    logic clk_sys = 0, rst = 1, sfrWr = 0, sfrRd = 0, microsecondTick = 0;
    logic [7:0] sfrAddr = 0, sfrWdata = 0, analogDivider = 8'h18, sfrRdata, gainValue, d;
    logic [4:0] sampleMultiplier;
    logic [2:0] gainCode;
    logic [6:0] offsetDacMagnitude;
    logic sfrHit, referenceClockSelect, burnoutCurrentEnable, internalReferenceEnable, referenceLevelHigh;
    logic inputBufferEnable, offsetDacEnable, offsetDacNegative, modTick, refTick;
    int n_errors = 0, samples_checked = 0, tickCnt = 0, g;
    logic [7:0] v [5] = '{8'h00, 8'h80, 8'h81, 8'h7F, 8'hFF};
    logic [4:0] m [8] = '{5'h01, 5'h01, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
    afc_top afc_top_i (.clk_sys, .rst, .sfrAddr, .sfrWdata, .sfrWr, .sfrRd, .analogDivider, .microsecondTick,
        .sfrRdata, .sfrHit, .referenceClockSelect, .burnoutCurrentEnable, .internalReferenceEnable,
        .referenceLevelHigh, .inputBufferEnable, .gainCode, .gainValue, .sampleMultiplier, .offsetDacEnable,
        .offsetDacNegative, .offsetDacMagnitude, .modTick, .refTick);
    always #25 clk_sys = ~clk_sys;
    // One microsecond is 20 clocks at 20 MHz
    always @(negedge clk_sys) begin
        tickCnt = (tickCnt + 1) % 20;
        microsecondTick <= (tickCnt == 0);
    end
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        sfrAddr = a;
        sfrWdata = dat;
        sfrWr = 1;
        @(negedge clk_sys);
        sfrWr = 0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        sfrAddr = a;
        sfrRd = 1;
        @(negedge clk_sys);
        sfrRd = 0;
        check(sfrRdata, e);
        check({7'h00, sfrHit}, {7'h00, h});
        @(negedge clk_sys);
    endtask
    // Gap in clocks between two pulses of the chosen tick
    task automatic gap(input logic sel, input int e);
        int n;
        for (n = 0; n < 2000 && (sel ? refTick : modTick) !== 1'b1; n++) @(negedge clk_sys);
        if (n == 2000) begin
            n_errors++;
            give_verdict;
        end
        @(negedge clk_sys);
        for (n = 1; n < 2000 && (sel ? refTick : modTick) !== 1'b1; n++) @(negedge clk_sys);
        if (n == 2000) begin
            n_errors++;
            give_verdict;
        end
        check({7'h00, n == e}, 8'h01);
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 0;
        rd(8'hDC, 8'h30, 1);
        rd(8'hE6, 8'h00, 1);
        wr(8'h77, 8'hFF);
        rd(8'h77, 8'h00, 0);
        rd(8'hDC, 8'h30, 1);
        $display("Register map test done");
        // Burnout only ever set together with the buffer
        for (g = 0; g < 8; g++) begin
            d = (g[0] ? 8'hD8 : 8'h20) | 8'(g);
            wr(8'hDC, d);
            check(gainValue, 8'h01 << g);
            check({3'h0, sampleMultiplier}, {3'h0, m[g]});
            check({referenceClockSelect, burnoutCurrentEnable, internalReferenceEnable, referenceLevelHigh,
                inputBufferEnable, gainCode}, d);
            rd(8'hDC, d, 1);
        end
        $display("Gain sweep done");
        for (g = 0; g < 5; g++) begin
            wr(8'hE6, v[g]);
            check({offsetDacNegative, offsetDacMagnitude}, v[g][6:0] != 7'h00 ? v[g] : 8'h00);
            check({7'h00, offsetDacEnable}, {7'h00, v[g][6:0] != 7'h00});
            rd(8'hE6, v[g], 1);
        end
        $display("Offset DAC test done");
        wr(8'hDC, 8'h20);
        gap(1, 100);
        gap(0, 1600);
        wr(8'hDC, 8'hA0);
        gap(1, 80);
        $display("Clock tick test done");
        rst = 1;
        @(negedge clk_sys);
        rst = 0;
        rd(8'hDC, 8'h30, 1);
        $display("Reset test done");
        give_verdict;
    end
endmodule
